/* File: hw/dmcr_pkg.sv */
/*
 * Package for the DAC mode-control register bank: register indices, field positions,
 * reset values, soft-restart length and the carrier structs.
 * Assumes nothing of its surroundings; imported by the register bank module.
 */
package dmcr_pkg;

	// Control word layout: bit 15 fixed zero, index in 14:8, data in 7:0
	localparam int IDX_W       = 7;
	localparam int DATA_W      = 8;
	localparam int WORD_ZERO_B = 15;
	localparam int IDX_MSB     = 14;
	localparam int IDX_LSB     = 8;

	// Register indices
	localparam logic [6:0] IDX_ATTEN_CH1   = 7'h01;
	localparam logic [6:0] IDX_ATTEN_CH2   = 7'h02;
	localparam logic [6:0] IDX_ATTEN_CH3   = 7'h03;
	localparam logic [6:0] IDX_ATTEN_CH4   = 7'h04;
	localparam logic [6:0] IDX_ATTEN_CH5   = 7'h05;
	localparam logic [6:0] IDX_ATTEN_CH6   = 7'h06;
	localparam logic [6:0] IDX_SILENCE_1_6 = 7'h07;
	localparam logic [6:0] IDX_DISABLE_1_6 = 7'h08;
	localparam logic [6:0] IDX_FORMAT      = 7'h09;
	localparam logic [6:0] IDX_DEEMPH      = 7'h0a;
	localparam logic [6:0] IDX_INTERP      = 7'h0c;
	localparam logic [6:0] IDX_FLAG_RANGE  = 7'h0d;
	localparam logic [6:0] IDX_SILENCE_ST  = 7'h0e;
	localparam logic [6:0] IDX_ATTEN_CH7   = 7'h10;
	localparam logic [6:0] IDX_ATTEN_CH8   = 7'h11;
	localparam logic [6:0] IDX_SILENCE_7_8 = 7'h12;
	localparam logic [6:0] IDX_DISABLE_7_8 = 7'h13;

	// Reset values of the stored bytes
	localparam logic [7:0] RST_ATTEN       = 8'hff;  // 0 dB, no attenuation
	localparam logic [7:0] RST_SILENCE     = 8'h00;
	localparam logic [7:0] RST_DISABLE     = 8'h00;
	localparam logic [7:0] RST_FORMAT      = 8'h05;  // Left-justified, sharp roll-off
	localparam logic [7:0] RST_DEEMPH      = 8'h00;  // Off, 44.1 kHz, normal phase
	localparam logic [7:0] RST_INTERP      = 8'h00;
	localparam logic [7:0] RST_FLAG_RANGE  = 8'h00;  // 0 to -63 dB range

	// Field positions
	localparam int FMT_LSB     = 0;
	localparam int ROLLOFF_B   = 5;
	localparam int DEEMPH_EN_B = 0;
	localparam int DMF_LSB     = 3;
	localparam int INVERT_B    = 5;
	localparam int FLAGPOL_B   = 6;
	localparam int RESTART_B   = 7;
	localparam int OVER_B      = 7;
	localparam int RANGE_B     = 7;
	localparam int ROUTE_LSB   = 5;

	// Writable-bit mask of the soft mute 7-8 register: test bits are stored as written
	localparam logic [7:0] MASK_SIL_7_8 = 8'hff;

	// Soft restart holds the bank in reset this many system clocks
	localparam int RESTART_CYCLES = 1024;

	// Host access carrier
	typedef struct packed {
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
		logic [6:0] idx;   // Register index
		logic [7:0] data;  // Write data
	} dmcr_req_t;

	// Decoded mode settings to the audio path
	typedef struct packed {
		logic [7:0][7:0] atten_level;          // Per channel attenuation
		logic [7:0]      soft_silence;         // Per channel soft mute
		logic [7:0]      channel_disable;      // Per channel disable
		logic [2:0]      audio_format;         // Serial audio format
		logic            rolloff_select;       // Slow roll-off when set
		logic            deemph_enable;        // De-emphasis on all channels
		logic [1:0]      deemph_rate;          // De-emphasis sample rate
		logic            output_invert;        // Output phase invert
		logic            silence_flag_polarity;// Zero-flag polarity
		logic            over_rate;            // Oversampling rate control
		logic [1:0]      silence_flag_routing; // Zero-flag combination
		logic            atten_range_select;   // 1 dB step range when set
	} dmcr_mode_t;

endpackage : dmcr_pkg

/* File: hw/dmcr_regs.sv */
/*
 * Mode-control register bank of an eight-channel audio DAC.
 * Assumes a serial port front end (SPI or I2C) that hands over one decoded 16-bit
 * control word per access as a one-cycle strobe, synchronous to clk.
 */
// Function
// - Eight attenuation bytes, reset to 0 dB
// - Range select bit, reset 0.5 dB steps
// - Format field, reset left-justified 24-bit
// - Roll-off select bit, reset sharp
// - De-emphasis enable, reset disabled
// - De-emphasis rate field, reset 44.1 kHz
// - Zero-detect status readable over I2C only
// - Word: zero, 7-bit index, data byte
// - Undefined index acknowledged, write discarded
// - Soft restart resets bank 1024 clocks
`timescale 1ns/10ps
`default_nettype none

module dmcr_regs
	import dmcr_pkg::*;
#(
	parameter int RESTART_LEN = RESTART_CYCLES  // Soft restart length in clocks
) (
	input  wire logic        clk,            // 10 MHz system clock
	input  wire logic        rst_n,          // Power-on reset, active low
	input  wire logic        wr_stb,         // Write word strobe, one cycle
	input  wire logic        rd_stb,         // Read request strobe, one cycle
	input  wire logic [15:0] ctrl_word,      // Control word, index and data
	input  wire logic        via_i2c,        // Access came over I2C
	input  wire logic [7:0]  zero_detect,    // Per channel zero detect
	output logic             ack,            // Access accepted
	output logic [7:0]       rd_data,        // Read data byte
	output logic             rd_valid,       // Read data valid pulse
	output logic             in_restart,     // Soft restart in progress
	output dmcr_mode_t       mode            // Decoded settings
);

	logic        rst_s1_r;              // Reset release stage one
	logic        rst_s2_r;              // Reset release stage two
	logic [10:0] restart_cnt_r;         // Soft restart counter
	logic        restart_r;             // Soft restart active
	logic [7:0]  atten_r [8];           // Attenuation bytes
	logic [7:0]  sil16_r;               // Soft mute 1-6 register
	logic [7:0]  sil78_r;               // Soft mute 7-8 register
	logic [7:0]  dis16_r;               // Disable 1-6 register
	logic [7:0]  dis78_r;               // Disable 7-8 register
	logic [7:0]  fmt_r;                 // Format and roll-off register
	logic [7:0]  deemph_r;              // De-emphasis and phase register
	logic [7:0]  interp_r;              // Oversampling register
	logic [7:0]  flag_r;                // Flag routing and range register
	logic [7:0]  zero_r;                // Registered zero-detect status
	logic [6:0]  widx;                  // Index of the access
	logic [7:0]  wdat;                  // Data byte of the access
	logic        word_ok;               // Bit 15 zero
	logic        bank_rst_n;            // Combined bank reset
	logic [7:0]  rd_mux;                // Read value of index

	// Release power-on reset through two flops
	// so that no flop leaves reset on an edge where the release itself may settle late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Split the word; a word with bit 15 set is not a control word
	assign widx    = ctrl_word[IDX_MSB:IDX_LSB];
	assign wdat    = ctrl_word[DATA_W-1:0];
	assign word_ok = ~ctrl_word[WORD_ZERO_B];

	// Soft restart counter: runs while the bank is held in reset
	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			restart_r     <= 1'b0;
			restart_cnt_r <= 11'h000;
		end else if (restart_r) begin
			// Counts the restart period then lets the bank go
			if (restart_cnt_r == 11'(RESTART_LEN - 1)) begin
				restart_r     <= 1'b0;
				restart_cnt_r <= 11'h000;
			end else begin
				restart_cnt_r <= restart_cnt_r + 11'h001;
			end
		end else if (wr_stb && word_ok && widx == IDX_DEEMPH && wdat[RESTART_B]) begin
			restart_r <= 1'b1;
		end
	end

	// Bank held in reset during restart, acting as at power-on
	// A write that arrives inside the restart period is lost, as it would be at power-on
	assign bank_rst_n = rst_s2_r & ~restart_r;
	assign in_restart = restart_r;

	// Attenuation bytes, one per channel
	// Only the target level is kept; stepping toward it is done downstream
	always_ff @(posedge clk) begin
		if (!bank_rst_n) begin
			for (int i = 0; i < 8; i++) begin
				atten_r[i] <= RST_ATTEN;
			end
		end else if (wr_stb && word_ok) begin
			// Channel 1-6 at indices 1-6, channels 7-8 at 16-17
			case (widx)
				IDX_ATTEN_CH1: atten_r[0] <= wdat;
				IDX_ATTEN_CH2: atten_r[1] <= wdat;
				IDX_ATTEN_CH3: atten_r[2] <= wdat;
				IDX_ATTEN_CH4: atten_r[3] <= wdat;
				IDX_ATTEN_CH5: atten_r[4] <= wdat;
				IDX_ATTEN_CH6: atten_r[5] <= wdat;
				IDX_ATTEN_CH7: atten_r[6] <= wdat;
				IDX_ATTEN_CH8: atten_r[7] <= wdat;
				default: ;  // Other indices leave these alone
			endcase
		end
	end

	// Control registers; undefined indices store nothing
	// Test bits are kept as written so the host reads back what it sent
	always_ff @(posedge clk) begin
		if (!bank_rst_n) begin
			sil16_r  <= RST_SILENCE;
			sil78_r  <= RST_SILENCE;
			dis16_r  <= RST_DISABLE;
			dis78_r  <= RST_DISABLE;
			fmt_r    <= RST_FORMAT;
			deemph_r <= RST_DEEMPH;
			interp_r <= RST_INTERP;
			flag_r   <= RST_FLAG_RANGE;
		end else if (wr_stb && word_ok) begin
			case (widx)
				IDX_SILENCE_1_6: sil16_r  <= wdat;
				IDX_SILENCE_7_8: sil78_r  <= wdat & MASK_SIL_7_8;
				IDX_DISABLE_1_6: dis16_r  <= wdat;
				IDX_DISABLE_7_8: dis78_r  <= wdat;
				IDX_FORMAT:      fmt_r    <= wdat;
				// Restart bit is not stored; the counter takes it
				IDX_DEEMPH:      deemph_r <= {1'b0, wdat[6:0]};
				IDX_INTERP:      interp_r <= wdat;
				IDX_FLAG_RANGE:  flag_r   <= wdat;
				default: ;  // Reserved, status and undefined indices discarded
			endcase
		end
	end

	// Status sampled each cycle so reads see a stable byte
	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			zero_r <= 8'h00;
		end else begin
			zero_r <= zero_detect;
		end
	end

	// Read selection of the addressed byte
	always_comb begin
		case (widx)
			IDX_ATTEN_CH1:   rd_mux = atten_r[0];
			IDX_ATTEN_CH2:   rd_mux = atten_r[1];
			IDX_ATTEN_CH3:   rd_mux = atten_r[2];
			IDX_ATTEN_CH4:   rd_mux = atten_r[3];
			IDX_ATTEN_CH5:   rd_mux = atten_r[4];
			IDX_ATTEN_CH6:   rd_mux = atten_r[5];
			IDX_ATTEN_CH7:   rd_mux = atten_r[6];
			IDX_ATTEN_CH8:   rd_mux = atten_r[7];
			IDX_SILENCE_1_6: rd_mux = sil16_r;
			IDX_SILENCE_7_8: rd_mux = sil78_r;
			IDX_DISABLE_1_6: rd_mux = dis16_r;
			IDX_DISABLE_7_8: rd_mux = dis78_r;
			IDX_FORMAT:      rd_mux = fmt_r;
			IDX_DEEMPH:      rd_mux = deemph_r;
			IDX_INTERP:      rd_mux = interp_r;
			IDX_FLAG_RANGE:  rd_mux = flag_r;
			// Status only over I2C; SPI has no read path for it
			IDX_SILENCE_ST:  rd_mux = via_i2c ? zero_r : 8'h00;
			default:         rd_mux = 8'h00;  // Undefined reads as zero
		endcase
	end

	// Read data register, updated only on a read strobe
	// The byte holds until the next read, so a slow port front end may fetch it late
	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_stb;
			if (rd_stb) begin
				rd_data <= rd_mux;
			end
		end
	end

	// Every access is acknowledged, defined or not
	// so that a stray index never stalls the serial port front end
	assign ack = wr_stb | rd_stb;

	// Decoded settings for the audio path
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			mode.atten_level[i] = atten_r[i];
		end
		mode.soft_silence          = {sil78_r[1:0], sil16_r[5:0]};
		mode.channel_disable       = {dis78_r[1:0], dis16_r[5:0]};
		mode.audio_format          = fmt_r[FMT_LSB +: 3];
		mode.rolloff_select        = fmt_r[ROLLOFF_B];
		mode.deemph_enable         = deemph_r[DEEMPH_EN_B];
		mode.deemph_rate           = deemph_r[DMF_LSB +: 2];
		mode.output_invert         = deemph_r[INVERT_B];
		mode.silence_flag_polarity = deemph_r[FLAGPOL_B];
		mode.over_rate             = interp_r[OVER_B];
		mode.silence_flag_routing  = flag_r[ROUTE_LSB +: 2];
		mode.atten_range_select    = flag_r[RANGE_B];
	end

endmodule : dmcr_regs

`default_nettype wire

/* File: testbench/dmcr_regs_properties.sv */
/* Checker for the mode-control bank, bound to dmcr_regs.
   Assumes one clock and the one-cycle strobe front end. */
`timescale 1ns/10ps
`default_nettype none
module dmcr_regs_properties
	import dmcr_pkg::*;
#(
	parameter int RESTART_LEN = RESTART_CYCLES  // Restart length in clocks
) (
	input  wire logic        clk,         // System clock
	input  wire logic        rst_n,       // Reset, active low
	input  wire logic        wr_stb,      // Write strobe
	input  wire logic        rd_stb,      // Read strobe
	input  wire logic [15:0] ctrl_word,   // Control word
	input  wire logic        via_i2c,     // Access over I2C
	input  wire logic [7:0]  zero_detect, // Zero detect in
	input  wire logic        ack,         // Accepted
	input  wire logic [7:0]  rd_data,     // Read byte
	input  wire logic        rd_valid,    // Read valid
	input  wire logic        in_restart,  // Restart busy
	input  wire dmcr_mode_t  mode         // Settings
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [6:0] idx = ctrl_word[14:8];  // Addressed index
	int              cnt_r;                  // Restart cycles so far

	// Counts restart cycles; a counter since the length is a parameter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) cnt_r <= 0;
		else cnt_r <= in_restart ? cnt_r + 1 : 0;
	end

	AST_ACK: assert property (ack == (wr_stb || rd_stb)) else $error("ack wrong");
	AST_RD_PULSE: assert property (rd_stb |=> rd_valid) else $error("read valid missing");
	AST_RD_QUIET: assert property (!rd_stb |=> !rd_valid) else $error("stray read valid");
	AST_ATTEN_WR: assert property (wr_stb && ctrl_word[15:8] == {1'b0, IDX_ATTEN_CH1} && !in_restart
		|=> mode.atten_level[0] == $past(ctrl_word[7:0])) else $error("attenuation write lost");
	AST_BIT15: assert property (wr_stb && ctrl_word[15] && !in_restart |=> $stable(mode))
		else $error("word with bit 15 set changed settings");
	AST_RESTART_GO: assert property (wr_stb && ctrl_word[15:7] == {1'b0, IDX_DEEMPH, 1'b1} && !in_restart
		|=> in_restart ##1 (mode.audio_format == RST_FORMAT[2:0] && mode.atten_level[0] == RST_ATTEN))
		else $error("restart did not reset");
	AST_RESTART_MAX: assert property (in_restart |-> cnt_r < RESTART_LEN) else $error("restart too long");
	AST_RESTART_LEN: assert property ($fell(in_restart) |-> cnt_r == RESTART_LEN) else $error("restart short");
	AST_STAT_SPI: assert property (rd_stb && idx == IDX_SILENCE_ST && !via_i2c |=> rd_data == 8'h00)
		else $error("status readable over SPI");
	AST_STAT_I2C: assert property (rd_stb && idx == IDX_SILENCE_ST && via_i2c && !in_restart
		&& $stable(zero_detect) |=> rd_data == $past(zero_detect)) else $error("status read wrong");
	cover property (wr_stb && idx == IDX_DEEMPH && ctrl_word[7]);
	cover property (rd_stb && via_i2c);
	cover property ($fell(in_restart));
endmodule : dmcr_regs_properties
`default_nettype wire

/* File: testbench/dmcr_host.sv */
/* Host controller model issuing control words to the bank.
   Assumes callers stand just past a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module dmcr_host (
	input  wire logic        clk,       // System clock
	output logic             wr_stb,    // Write strobe
	output logic             rd_stb,    // Read strobe
	output logic [15:0]      ctrl_word, // Control word
	output logic             via_i2c,   // Access over I2C
	input  wire logic        ack,       // Accepted
	input  wire logic [7:0]  rd_data    // Read byte
);
	int n_reads = 0;  // Read accesses issued so far

	initial begin
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		ctrl_word = 16'h0000;
		via_i2c = 1'b1;
	end

	// One word held over one edge; strobe stays up for back-to-back use
	task automatic xfer(input logic rd, input logic [15:0] w, input logic i2c, output logic ok);
		wr_stb = !rd;
		rd_stb = rd;
		ctrl_word = w;
		via_i2c = i2c;
		@(posedge clk);
		ok = ack;
		#1;
	endtask : xfer

	// Released word toggles so nothing relies on a stale value
	task automatic idle();
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		ctrl_word = ~ctrl_word;
	endtask : idle

	// Bit 15 kept zero; index and data in place
	task automatic wr(input logic [6:0] idx, input logic [7:0] d, output logic ok);
		xfer(1'b0, {1'b0, idx, d}, 1'b1, ok);
	endtask : wr

	task automatic rd(input logic [6:0] idx, input logic i2c, output logic [7:0] d);
		logic ok;
		n_reads++;
		xfer(1'b1, {1'b0, idx, 8'h00}, i2c, ok);
		idle();
		@(posedge clk);
		d = rd_data;
		#1;
	endtask : rd
endmodule : dmcr_host
`default_nettype wire

/* File: testbench/tb.sv */
/* Self-checking bench for the register bank.
   Assumes the host model drives all access strobes. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	import dmcr_pkg::*;
	localparam int RLEN = 8;  // Short restart for simulation
	logic        clk, rst_n, wr_stb, rd_stb, via_i2c, ack, rd_valid, in_restart, ok;
	logic [15:0] ctrl_word;
	logic [7:0]  zero_detect, rd_data, d;
	dmcr_mode_t  mode;
	int          bad_count = 0, n_checks = 0, cyc = 0;
	int          n_valid = 0;  // Read valid pulses seen

	dmcr_regs #(.RESTART_LEN(RLEN)) dut (.clk(clk), .rst_n(rst_n), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.ctrl_word(ctrl_word), .via_i2c(via_i2c), .zero_detect(zero_detect), .ack(ack),
		.rd_data(rd_data), .rd_valid(rd_valid), .in_restart(in_restart), .mode(mode));
	dmcr_host host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .ctrl_word(ctrl_word),
		.via_i2c(via_i2c), .ack(ack), .rd_data(rd_data));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Hang guard, and a count of read valid pulses
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_valid) n_valid <= n_valid + 1;
		if (cyc == 2000) begin
			bad_count++;
			results();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic results();
		if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results

	function automatic logic [7:0] rst_val(int i);
		return (i < 7 || i > 15 && i < 18) ? 8'hff : (i == 9 ? 8'h05 : 8'h00);
	endfunction : rst_val

	// Reserved factory indices are never issued and test bits stay zero
	initial begin
		rst_n = 1'b0;
		zero_detect = 8'ha5;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		for (int i = 1; i < 20; i++) if (i != 11 && i != 15 && i != 14) begin
			host.rd(7'(i), 1'b1, d);
			chk(d, rst_val(i));
		end
		chk({mode.audio_format, mode.rolloff_select, mode.deemph_enable, mode.deemph_rate,
			mode.atten_range_select}, 8'ha0);
		for (int i = 1; i < 18; i++) if (i < 7 || i > 15) begin
			host.wr(7'(i), 8'(i * 13), ok);
			chk({7'h0, ok}, 8'h01);
		end
		host.wr(IDX_FORMAT, 8'h24, ok);
		host.wr(IDX_DEEMPH, 8'h79, ok);
		host.wr(IDX_FLAG_RANGE, 8'he0, ok);
		host.wr(IDX_SILENCE_1_6, 8'h3f, ok);
		host.wr(IDX_SILENCE_7_8, 8'h01, ok);
		host.wr(IDX_DISABLE_1_6, 8'h2a, ok);
		host.wr(IDX_DISABLE_7_8, 8'h02, ok);
		host.wr(IDX_INTERP, 8'h80, ok);
		host.xfer(1'b0, {1'b1, IDX_ATTEN_CH1, 8'h00}, 1'b1, ok);
		host.wr(7'h20, 8'h00, ok);
		chk({7'h0, ok}, 8'h01);
		host.idle();
		chk({mode.audio_format, mode.rolloff_select, mode.deemph_enable, mode.deemph_rate,
			mode.atten_range_select}, 8'h9f);
		chk(mode.soft_silence, 8'h7f);
		chk(mode.channel_disable, 8'haa);
		chk({mode.output_invert, mode.silence_flag_polarity, mode.over_rate, mode.silence_flag_routing, 3'h0},
			8'hf8);
		for (int i = 1; i < 18; i++) if (i < 7 || i > 15) begin
			host.rd(7'(i), 1'b1, d);
			chk(d, 8'(i * 13));
			chk(mode.atten_level[i < 7 ? i - 1 : i - 10], 8'(i * 13));
		end
		host.rd(IDX_SILENCE_ST, 1'b1, d);
		chk(d, 8'ha5);
		host.rd(IDX_SILENCE_ST, 1'b0, d);
		chk(d, 8'h00);
		zero_detect = 8'h3c;
		@(posedge clk);
		#1;
		host.rd(IDX_SILENCE_ST, 1'b1, d);
		chk(d, 8'h3c);
		host.wr(IDX_DEEMPH, 8'h80, ok);
		host.wr(IDX_ATTEN_CH2, 8'h11, ok);
		host.idle();
		chk({7'h0, in_restart}, 8'h01);
		repeat (RLEN + 2) @(posedge clk);
		#1;
		chk({7'h0, in_restart}, 8'h00);
		host.rd(IDX_ATTEN_CH2, 1'b1, d);
		chk(d, 8'hff);
		host.rd(IDX_FORMAT, 1'b1, d);
		chk(d, 8'h05);
		host.rd(IDX_DEEMPH, 1'b1, d);
		chk(d, 8'h00);
		chk(8'(n_valid), 8'(host.n_reads));
		results();
	end
endmodule : tb

bind dmcr_regs dmcr_regs_properties #(.RESTART_LEN(RESTART_LEN)) u_props (.clk(clk), .rst_n(rst_n),
	.wr_stb(wr_stb), .rd_stb(rd_stb), .ctrl_word(ctrl_word), .via_i2c(via_i2c),
	.zero_detect(zero_detect), .ack(ack), .rd_data(rd_data), .rd_valid(rd_valid),
	.in_restart(in_restart), .mode(mode));
`default_nettype wire
